// File: pkg/pcr_map.vh
/*
 * Register map, field positions, reset values and timing figures of the
 * receive PCS and reduced-interface configuration block.
 * Assumes a 25 MHz system clock and word-aligned Avalon-MM byte addresses.
 */
`ifndef PCR_MAP_VH
`define PCR_MAP_VH

// Register indices; byte address is four times the index
`define PCR_IDX_PCS 6'h16
`define PCR_IDX_RBR 6'h17
`define PCR_IDX_IST 6'h1C
`define PCR_IDX_IMSK 6'h1D

// Configuration register fields
`define PCR_B_SDALGO 8
`define PCR_B_DESCTO 7
`define PCR_B_FORCE 5
`define PCR_B_NRZIBYP 2

// Reduced-interface register fields
`define PCR_B_RMODE 5
`define PCR_B_OLDREV 4
`define PCR_B_OVF 3
`define PCR_B_UNF 2
`define PCR_B_ELAST_HI 1
`define PCR_B_ELAST_LO 0

// Interrupt status and mask fields
`define PCR_B_IOVF 0
`define PCR_B_IUNF 1
`define PCR_B_ISYNC 2
`define PCR_IRQ_W 3

// Reset values
`define PCR_RST_SDALGO 1'b1
`define PCR_RST_ELAST 2'h1
`define PCR_RST_OLDREV 1'b0

// Elasticity tolerance in bits for each field code
`define PCR_TOL_00 5'hE
`define PCR_TOL_01 5'h2
`define PCR_TOL_10 5'h6
`define PCR_TOL_11 5'hA

// Descrambler loss-of-sync timeouts
`define PCR_CLK_KHZ 25000
`define PCR_DESC_SHORT_NS 722000
`define PCR_DESC_LONG_NS 2000000

`endif

// File: rtl/pcr_elastic_track.v
/*
 * Receive elasticity buffer fill tracker: counts bits entering from the
 * recovered clock side and leaving on the reference side, and flags
 * overflow and underflow against the programmed tolerance.
 * Assumes both bit strobes are already in the system clock domain.
 */
module pcr_elastic_track #(
   parameter LW = 5
)(
   input wire clk,
   input wire rst,
   input wire pktStart,
   input wire wrBit,
   input wire rdBit,
   input wire [LW-1:0] tolBits,
   output reg overFlag,
   output reg underFlag,
   output wire overEvt,
   output wire underEvt
);

   reg [LW:0] level_q;
   wire [LW:0] tolW;
   wire [LW:0] limit;

   assign tolW = {1'b0, tolBits};
   assign limit = {tolBits, 1'b0};
   // Write past twice the tolerance, or read at zero, is a slip
   assign overEvt = wrBit & ~rdBit & (level_q == limit);
   assign underEvt = rdBit & ~wrBit & (level_q == {(LW+1){1'b0}});

   // Prefill to half depth at each packet start
   always @(posedge clk)
   begin
      if (rst)
         level_q <= {(LW+1){1'b0}};
      else if (pktStart)
         level_q <= tolW;
      else if (wrBit & ~rdBit & ~overEvt)
         level_q <= level_q + 1'b1;
      else if (rdBit & ~wrBit & ~underEvt)
         level_q <= level_q - 1'b1;
   end

   // Condition flags hold for the packet; a new slip beats the clear
   always @(posedge clk)
   begin
      if (rst)
      begin
         overFlag <= 1'b0;
         underFlag <= 1'b0;
      end
      else
      begin
         overFlag <= overEvt | (overFlag & ~pktStart);
         underFlag <= underEvt | (underFlag & ~pktStart);
      end
   end

endmodule

// File: rtl/pcr_rmii_cfg.v
/*
 * Configuration and status registers of the 100 Mbps receive PCS and the
 * reduced media-independent interface path, with the small pieces of
 * receive logic they steer: signal-detect choice, descrambler timeout,
 * forced link, NRZI bypass, MII/RMII routing and CRS_DV shaping.
 * Assumes an Avalon-MM master with waitrequest, a synchronous strap input
 * stable around reset, and receive strobes synchronous to clk.
 */
// Design decision made here: the Avalon-MM slave port.
`include "pcr_map.vh"

// Functional notes
// R1: Bit 8 resets to one, enhanced signal detect; zero picks reduced algorithm.
// R2: Descrambler timeout bit picks 2 ms when set, 722 us when clear.
// R3: Force bit 5 reports good 100 Mbps link regardless of receiver.
// R4: Bypass bit 2 removes NRZI coding from the data path.
// R5: Software writes zero to reserved bits of the configuration register.
// R6: With reduced interface off, data bypasses RMII logic and plain MII appears.
// R7: Interface select bit 5 resets from strap, stays writable; one means RMII.
// R8: Revision bit clear: CRS_DV toggles at packet end after carrier drops.
// R9: Revision bit set: CRS_DV stays high until last data, no toggle.
// R10: Overflow bit 3 reads one when receive FIFO overflowed.
// R11: Underflow bit 2 reads one when receive FIFO underflowed.
// R12: Elasticity buffer absorbs clock offsets; minimum covers standard frames.
// R13: Two-bit elasticity field resets 01; codes give 14, 2, 6, 10 bits.
// R14: Bits 15:6 of the interface register ignore writes, read zero.
// R15: Registers are 16 bits; writes touch writable fields; status is live.
module pcr_rmii_cfg #(
   parameter DESC_SHORT_CYC = `PCR_DESC_SHORT_NS / 1000 * `PCR_CLK_KHZ / 1000,
   parameter DESC_LONG_CYC = `PCR_DESC_LONG_NS / 1000 * `PCR_CLK_KHZ / 1000,
   parameter TW = 17
)(
   input wire clk,
   input wire rst,
   input wire [7:0] address,
   input wire read,
   input wire write,
   input wire [31:0] writedata,
   input wire [3:0] byteenable,
   output reg [31:0] readdata,
   output wire waitrequest,
   output wire irq,
   input wire rmiiStrap,
   input wire rxBitIn,
   input wire rxBitStb,
   input wire rxRefStb,
   input wire rxPktStart,
   input wire rxIdleSeen,
   input wire link100Qualified,
   input wire crsIn,
   input wire rxDvIn,
   input wire [3:0] rxdIn,
   output reg rxBitOut,
   output reg sigDetectAlgoSel,
   output reg link100Good,
   output reg descramblerLocked,
   output reg miiCrs,
   output reg miiRxDv,
   output reg [3:0] miiRxd,
   output reg crsDv,
   output reg [3:0] rmiiRxd
);

   // Elasticity field code to tolerance in bits
   function [4:0] tolOf;
      input [1:0] code;
      begin
         case (code)
            2'h0: tolOf = `PCR_TOL_00;
            2'h1: tolOf = `PCR_TOL_01;
            2'h2: tolOf = `PCR_TOL_10;
            default: tolOf = `PCR_TOL_11;
         endcase
      end
   endfunction

   // Byte-lane merge for a 16-bit register
   function [15:0] merge16;
      input [15:0] old;
      input [15:0] wd;
      input [1:0] be;
      begin
         merge16 = old;
         if (be[0])
            merge16[7:0] = wd[7:0];
         if (be[1])
            merge16[15:8] = wd[15:8];
      end
   endfunction

   reg ackQ;
   reg sdAlgo_q;
   reg descTo_q;
   reg force_q;
   reg nrziByp_q;
   reg rmode_q;
   reg oldRev_q;
   reg [1:0] elast_q;
   reg [`PCR_IRQ_W-1:0] ist_q;
   reg [`PCR_IRQ_W-1:0] imsk_q;
   reg [TW-1:0] descCnt_q;
   reg nrziPrev_q;
   reg toggle_q;
   reg [15:0] rdMux;
   reg [15:0] pcsWr;
   reg [15:0] rbrWr;
   reg [`PCR_IRQ_W-1:0] istNext;

   wire req;
   wire wrStb;
   wire [5:0] idx;
   wire overFlag;
   wire underFlag;
   wire overEvt;
   wire underEvt;
   wire syncLostEvt;
   wire [TW-1:0] descLimit;
   wire [`PCR_IRQ_W-1:0] evts;
   wire [15:0] pcsM;
   wire [15:0] rbrM;

   assign idx = address[7:2];
   assign req = read | write;
   // One wait cycle: the answer comes on the second edge of a request
   assign waitrequest = req & ~ackQ;
   // Writes land on the edge where waitrequest is sampled low
   assign wrStb = write & ackQ;

   // Ack toggles so back-to-back requests each see one wait cycle
   always @(posedge clk)
   begin
      if (rst)
         ackQ <= 1'b0;
      else
         ackQ <= req & ~ackQ;
   end

   // Register images as seen by the bus; reserved bits stay zero
   always @*
   begin
      pcsWr = 16'h0000;
      pcsWr[`PCR_B_SDALGO] = sdAlgo_q; // [R1]
      pcsWr[`PCR_B_DESCTO] = descTo_q;
      pcsWr[`PCR_B_FORCE] = force_q;
      pcsWr[`PCR_B_NRZIBYP] = nrziByp_q;
      rbrWr = 16'h0000; // [R14]
      rbrWr[`PCR_B_RMODE] = rmode_q;
      rbrWr[`PCR_B_OLDREV] = oldRev_q;
      rbrWr[`PCR_B_OVF] = overFlag; // [R10] [R15]
      rbrWr[`PCR_B_UNF] = underFlag; // [R11]
      rbrWr[`PCR_B_ELAST_HI:`PCR_B_ELAST_LO] = elast_q;
   end

   // Write images merged by byte lane ahead of the register processes
   assign pcsM = merge16(pcsWr, writedata[15:0], byteenable[1:0]);
   assign rbrM = merge16(rbrWr, writedata[15:0], byteenable[1:0]);

   // Read multiplexer; unmapped words read zero
   always @*
   begin
      case (idx)
         `PCR_IDX_PCS: rdMux = pcsWr;
         `PCR_IDX_RBR: rdMux = rbrWr;
         `PCR_IDX_IST: rdMux = {13'h0000, ist_q};
         `PCR_IDX_IMSK: rdMux = {13'h0000, imsk_q};
         default: rdMux = 16'h0000;
      endcase
   end

   // Read data captured at the wait edge, stands through the answer cycle
   always @(posedge clk)
   begin
      if (rst)
         readdata <= 32'h00000000;
      else if (read & ~ackQ)
         readdata <= {16'h0000, rdMux};
   end

   // Configuration register; writes to reserved positions are dropped
   always @(posedge clk)
   begin
      if (rst)
      begin
         sdAlgo_q <= `PCR_RST_SDALGO; // [R1]
         descTo_q <= 1'b0;
         force_q <= 1'b0;
         nrziByp_q <= 1'b0;
      end
      else if (wrStb && idx == `PCR_IDX_PCS)
      begin
         // Only defined fields are stored, whatever software puts elsewhere
         sdAlgo_q <= pcsM[`PCR_B_SDALGO]; // [R1] [R5] [R15]
         descTo_q <= pcsM[`PCR_B_DESCTO]; // [R2]
         force_q <= pcsM[`PCR_B_FORCE]; // [R3]
         nrziByp_q <= pcsM[`PCR_B_NRZIBYP]; // [R4]
      end
   end

   // Interface register; mode bit caught from the strap while reset is held
   always @(posedge clk)
   begin
      if (rst)
      begin
         rmode_q <= rmiiStrap; // [R7]
         oldRev_q <= `PCR_RST_OLDREV; // [R8]
         elast_q <= `PCR_RST_ELAST; // [R13]
      end
      else if (wrStb && idx == `PCR_IDX_RBR)
      begin
         // Status bits and bits 15:6 are not stored
         rmode_q <= rbrM[`PCR_B_RMODE]; // [R7] [R14]
         oldRev_q <= rbrM[`PCR_B_OLDREV]; // [R9]
         elast_q <= rbrM[`PCR_B_ELAST_HI:`PCR_B_ELAST_LO]; // [R13]
      end
   end

   assign evts = {syncLostEvt, underEvt, overEvt};

   // Sticky events, write one to clear; a new event beats the clear
   always @*
   begin
      istNext = ist_q;
      if (wrStb && idx == `PCR_IDX_IST && byteenable[0])
         istNext = ist_q & ~writedata[`PCR_IRQ_W-1:0];
      istNext = istNext | evts;
   end

   always @(posedge clk)
   begin
      if (rst)
      begin
         ist_q <= {`PCR_IRQ_W{1'b0}};
         imsk_q <= {`PCR_IRQ_W{1'b0}};
      end
      else
      begin
         ist_q <= istNext;
         if (wrStb && idx == `PCR_IDX_IMSK && byteenable[0])
            imsk_q <= writedata[`PCR_IRQ_W-1:0];
      end
   end

   assign irq = |(ist_q & imsk_q);

   // Fill tracker sized by the tolerance code
   pcr_elastic_track #(
      .LW(5)
   ) uTrack (
      .clk(clk),
      .rst(rst),
      .pktStart(rxPktStart),
      .wrBit(rxBitStb),
      .rdBit(rxRefStb),
      .tolBits(tolOf(elast_q)), // [R12] [R13]
      .overFlag(overFlag),
      .underFlag(underFlag),
      .overEvt(overEvt),
      .underEvt(underEvt)
   );

   // Timeout chosen live; a longer window keeps lock over jumbo frames
   assign descLimit = descTo_q ? DESC_LONG_CYC[TW-1:0] : DESC_SHORT_CYC[TW-1:0]; // [R2]
   assign syncLostEvt = descramblerLocked & (descCnt_q >= descLimit - 1'b1);

   // Lock watchdog: idle seen restarts it, expiry drops lock
   always @(posedge clk)
   begin
      if (rst)
      begin
         descCnt_q <= {TW{1'b0}};
         descramblerLocked <= 1'b0;
      end
      else if (rxIdleSeen)
      begin
         descCnt_q <= {TW{1'b0}};
         descramblerLocked <= 1'b1;
      end
      else if (syncLostEvt)
      begin
         descCnt_q <= {TW{1'b0}};
         descramblerLocked <= 1'b0; // [R2]
      end
      else if (descramblerLocked)
         descCnt_q <= descCnt_q + 1'b1;
   end

   // Link report and signal-detect choice
   always @(posedge clk)
   begin
      if (rst)
      begin
         link100Good <= 1'b0;
         sigDetectAlgoSel <= `PCR_RST_SDALGO;
      end
      else
      begin
         link100Good <= force_q | link100Qualified; // [R3]
         sigDetectAlgoSel <= sdAlgo_q; // [R1]
      end
   end

   // NRZI decode: a transition is a one; bypass passes bits raw
   always @(posedge clk)
   begin
      if (rst)
      begin
         nrziPrev_q <= 1'b0;
         rxBitOut <= 1'b0;
      end
      else if (rxBitStb)
      begin
         nrziPrev_q <= rxBitIn;
         rxBitOut <= nrziByp_q ? rxBitIn : (rxBitIn ^ nrziPrev_q); // [R4]
      end
   end

   // Tail phase after carrier drops while data is still draining; the phase
   // starts at zero on the first tail cycle so CRS_DV reads 1, 0, 1, 0 there
   always @(posedge clk)
   begin
      if (rst)
      begin
         toggle_q <= 1'b0;
      end
      else
      begin
         toggle_q <= (~crsIn & rxDvIn) ? ~toggle_q : 1'b0; // [R8]
      end
   end

   // Interface routing; the unused side is held quiet
   always @(posedge clk)
   begin
      if (rst)
      begin
         miiCrs <= 1'b0;
         miiRxDv <= 1'b0;
         miiRxd <= 4'h0;
         crsDv <= 1'b0;
         rmiiRxd <= 4'h0;
      end
      else if (!rmode_q)
      begin
         miiCrs <= crsIn; // [R6]
         miiRxDv <= rxDvIn;
         miiRxd <= rxdIn;
         crsDv <= 1'b0;
         rmiiRxd <= 4'h0;
      end
      else
      begin
         miiCrs <= 1'b0;
         miiRxDv <= 1'b0;
         miiRxd <= 4'h0;
         rmiiRxd <= rxDvIn ? rxdIn : 4'h0;
         if (crsIn)
            crsDv <= 1'b1;
         else if (oldRev_q)
            crsDv <= rxDvIn; // [R9]
         else
            crsDv <= rxDvIn & ~toggle_q; // [R8]
      end
   end

endmodule

// File: test/pcr_rmii_cfg_sva.sv
/* Port checker for pcr_rmii_cfg.
   Assumes one clock domain and a synchronous active-high reset. */
module pcr_rmii_cfg_sva (
   input logic clk,
   input logic rst,
   input logic [7:0] address,
   input logic read,
   input logic write,
   input logic [31:0] readdata,
   input logic waitrequest,
   input logic link100Qualified,
   input logic link100Good,
   input logic crsIn,
   input logic rxDvIn,
   input logic [3:0] rxdIn,
   input logic miiCrs,
   input logic miiRxDv,
   input logic [3:0] miiRxd,
   input logic crsDv,
   input logic [3:0] rmiiRxd
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   // Bus answers after at most one wait cycle
   a_wait_single: assert property ((read || write) && waitrequest |=> !waitrequest)
      else $error("waitrequest held past one cycle");
   a_read_upper: assert property (read && !waitrequest |-> readdata[31:16] == 16'h0000)
      else $error("upper read half not zero");
   a_rbr_reserved: assert property (read && !waitrequest && address == 8'h5C |->
      readdata[15:6] == 10'h000)
      else $error("interface register reserved bits set");
   a_pcs_reserved: assert property (read && !waitrequest && address == 8'h58 |->
      readdata[15:9] == 7'h00 && !readdata[6] && readdata[4:3] == 2'h0 && readdata[1:0] == 2'h0)
      else $error("config register reserved bits set");
   // Qualified link must always show as good, whatever the force bit
   a_link_good: assert property (!$past(rst) && $past(link100Qualified) |-> link100Good)
      else $error("qualified link not reported");
   a_path_excl: assert property (miiCrs || miiRxDv |-> !crsDv && rmiiRxd == 4'h0)
      else $error("both receive paths active");
   a_crsdv_cause: assert property (crsDv |-> $past(crsIn) || $past(rxDvIn))
      else $error("crsDv without carrier or data");
   a_mii_data: assert property (miiRxDv |-> miiRxd == $past(rxdIn))
      else $error("MII data not a copy of input");
endmodule

bind pcr_rmii_cfg pcr_rmii_cfg_sva pcr_rmii_cfg_sva_i (.clk, .rst, .address, .read, .write,
   .readdata, .waitrequest, .link100Qualified, .link100Good, .crsIn, .rxDvIn, .rxdIn, .miiCrs,
   .miiRxDv, .miiRxd, .crsDv, .rmiiRxd);

// File: test/pcr_mac_model.sv
/* Receive-side frame source and CRS_DV observer.
   Assumes go is a one-cycle pulse and the design is in RMII mode when dips matter. */
module pcr_mac_model (
   input logic clk,
   input logic go,
   input logic crsDv,
   output logic crsIn,
   output logic rxDvIn,
   output logic [3:0] rxdIn,
   output int dips
);
   timeunit 1ns;
   timeprecision 1ns;
   int t = 0;
   logic tailQ = 1'b0;
   initial
   begin
      crsIn = 1'b0;
      rxDvIn = 1'b0;
      rxdIn = 4'h0;
      dips = 0;
   end

   // Six carrier cycles then four data-only tail cycles; idle data keeps changing
   always @(posedge clk)
   begin
      crsIn <= t > 4;
      rxDvIn <= t > 0;
      rxdIn <= (t > 0) ? t[3:0] ^ 4'hA : ~rxdIn;
      if (tailQ && !crsDv)
         dips <= dips + 1;
      tailQ <= rxDvIn && !crsIn;
      if (t > 0)
         t <= t - 1;
      if (go)
      begin
         t <= 10;
         dips <= 0;
      end
   end
endmodule

// File: test/pcr_rmii_cfg_test.sv
/* Self-checking bench for pcr_rmii_cfg: register bus, status, interrupt, CRS_DV shaping.
   Assumes a 25 MHz clock and the designer's one-wait-cycle Avalon slave. */
module pcr_rmii_cfg_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, rst = 1, read = 0, write = 0, rmiiStrap = 1, go = 0;
   logic rxBitIn = 0, rxIdleSeen = 0, rxBitOut, descramblerLocked;
   logic rxBitStb = 0, rxRefStb = 0, rxPktStart = 0, link100Qualified = 0;
   logic [7:0] address = 8'h00;
   logic [31:0] writedata = 32'h00000000;
   logic [31:0] readdata;
   logic waitrequest, irq, crsIn, rxDvIn, sigDetectAlgoSel, link100Good, crsDv;
   logic [3:0] rxdIn;
   logic [15:0] expQ[$];
   logic [15:0] d;
   int errors = 0, samplesChecked = 0, seed = 44746, dips, n;

   always #20 clk = ~clk;

   pcr_rmii_cfg #(.DESC_SHORT_CYC(20), .DESC_LONG_CYC(50)) pcr_rmii_cfg_i (.clk, .rst,
      .address, .read, .write, .writedata, .byteenable(4'hF), .readdata, .waitrequest, .irq,
      .rmiiStrap, .rxBitIn, .rxBitStb, .rxRefStb, .rxPktStart, .rxIdleSeen,
      .link100Qualified, .crsIn, .rxDvIn, .rxdIn, .rxBitOut, .sigDetectAlgoSel,
      .link100Good, .descramblerLocked, .miiCrs(), .miiRxDv(), .miiRxd(), .crsDv,
      .rmiiRxd());
   pcr_mac_model pcr_mac_model_i (.clk, .go, .crsDv, .crsIn, .rxDvIn, .rxdIn, .dips);

   task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      samplesChecked++;
      if (g !== e)
      begin
         errors++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task final_report;
      if (errors == 0 && samplesChecked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // One bus cycle; request held until waitrequest is sampled low at a rising edge,
   // then released there; ends mid-cycle so outputs are looked at once settled
   task acc(input logic w, input logic [7:0] a, input logic [15:0] v);
      int k;
      k = 0;
      @(posedge clk);
      address <= a;
      writedata <= {16'h0000, v};
      read <= !w;
      write <= w;
      do
      begin
         @(posedge clk);
         k++;
      end while (waitrequest !== 1'b0 && k < 40);
      if (waitrequest !== 1'b0)
      begin
         errors++;
         final_report;
      end
      read <= 1'b0;
      write <= 1'b0;
      @(negedge clk);
   endtask

   task rd(input logic [7:0] a, input logic [15:0] e);
      expQ.push_back(e);
      acc(1'b0, a, 16'h0000);
   endtask

   // Packet start then cnt back-to-back strobes, write side or read side
   task strobes(input logic w, input int cnt);
      @(posedge clk);
      rxPktStart <= 1'b1;
      @(posedge clk);
      rxPktStart <= 1'b0;
      repeat (cnt)
      begin
         @(posedge clk);
         rxBitStb <= w;
         rxRefStb <= !w;
      end
      @(posedge clk);
      rxBitStb <= 1'b0;
      rxRefStb <= 1'b0;
      @(negedge clk);
   endtask

   task frame;
      @(posedge clk);
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      repeat (14) @(posedge clk);
   endtask

   // Idle pulse locks the descrambler; lock must stand w1 cycles and be gone w2 later
   task idle(input int w1, input int w2);
      @(posedge clk);
      rxIdleSeen <= 1'b1;
      @(posedge clk);
      rxIdleSeen <= 1'b0;
      repeat (w1) @(posedge clk);
      @(negedge clk);
      chk("locked", 16'h0001, descramblerLocked);
      repeat (w2) @(posedge clk);
      @(negedge clk);
      chk("unlocked", 16'h0000, descramblerLocked);
   endtask

   // Read results are matched against the oldest note at the answering edge
   always @(posedge clk)
      if (read && waitrequest === 1'b0)
      begin
         if (expQ.size() == 0)
            chk("readQueue", 16'h0001, 16'h0000);
         else
            chk("readdata", expQ.pop_front(), readdata[15:0]);
      end

   initial
   begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      rxBitIn <= 1'b1;
      rd(8'h58, 16'h0100);
      rd(8'h5C, 16'h0021);
      chk("algoSel", 16'h0001, sigDetectAlgoSel);
      acc(1'b1, 8'h58, 16'h01A4);
      rd(8'h58, 16'h01A4);
      chk("linkGood", 16'h0001, link100Good);
      strobes(1'b1, 1);
      chk("rxBit", 16'h0001, rxBitOut);
      acc(1'b1, 8'h58, 16'h0000);
      rd(8'h58, 16'h0000);
      chk("algoSel", 16'h0000, sigDetectAlgoSel);
      chk("linkGood", 16'h0000, link100Good);
      strobes(1'b1, 1);
      chk("rxBit", 16'h0000, rxBitOut);
      @(posedge clk);
      link100Qualified <= 1'b1;
      for (n = 0; n < 8; n++)
      begin
         d = (n < 4) ? 16'h0020 | n : $random(seed);
         acc(1'b1, 8'h5C, d);
         rd(8'h5C, d & 16'h0033);
      end
      // Widest tolerance: 14 extra bits fit, the 15th overflows
      acc(1'b1, 8'h5C, 16'h0020);
      strobes(1'b1, 14);
      rd(8'h5C, 16'h0020);
      strobes(1'b1, 15);
      rd(8'h5C, 16'h0028);
      acc(1'b1, 8'h5C, 16'h0021);
      strobes(1'b1, 3);
      rd(8'h5C, 16'h0029);
      acc(1'b1, 8'h74, 16'h0001);
      chk("irq", 16'h0001, irq);
      acc(1'b1, 8'h70, 16'h0001);
      chk("irq", 16'h0000, irq);
      strobes(1'b0, 3);
      rd(8'h5C, 16'h0025);
      chk("irq", 16'h0000, irq);
      rd(8'h70, 16'h0002);
      idle(15, 10);
      rd(8'h70, 16'h0006);
      acc(1'b1, 8'h58, 16'h0080);
      idle(40, 15);
      rd(8'h40, 16'h0000);
      frame;
      chk("dips", 16'h0002, dips[15:0]);
      acc(1'b1, 8'h5C, 16'h0031);
      frame;
      chk("dips", 16'h0000, dips[15:0]);
      acc(1'b1, 8'h5C, 16'h0001);
      frame;
      chk("crsDv", 16'h0000, crsDv);
      chk("dips", 16'h0004, dips[15:0]);
      final_report;
   end

   // Hang guard
   initial
   begin
      repeat (20000) @(posedge clk);
      errors++;
      final_report;
   end
endmodule
